/* pkg/aspl_consts.svh */
// constants of the angle sensor programming link
`ifndef ASPL_CONSTS_SVH
`define ASPL_CONSTS_SVH

// ***************************************************************
// clock and timing
// ***************************************************************
`define ASPL_CLK_MHZ      10
`define ASPL_SYNC_LAT     2
`define ASPL_TO_US        220
`define ASPL_TO_CYC       ((`ASPL_TO_US * `ASPL_CLK_MHZ) - `ASPL_SYNC_LAT - 1)
`define ASPL_TON_MS       5
`define ASPL_TON_CYC      (`ASPL_TON_MS * 1000 * `ASPL_CLK_MHZ)
`define ASPL_ENT_MS       30
`define ASPL_ENT_CYC      (`ASPL_ENT_MS * 1000 * `ASPL_CLK_MHZ)
`define ASPL_PUMP_MS      1
`define ASPL_PUMP_CYC     (`ASPL_PUMP_MS * 1000 * `ASPL_CLK_MHZ)

// ***************************************************************
// command byte fields and frame lengths
// ***************************************************************
`define ASPL_CMD_BITS     5'h07
`define ASPL_FRAME_BITS   5'h17
`define ASPL_TX_LAST      5'h0F
`define ASPL_REGION_REG   1'h1
`define ASPL_ENTRY_CMD    8'h9E
`define ASPL_ENTRY_SIG    16'h5AA5

`endif

/* pkg/aspl_pkg.sv */
// types of the angle sensor programming link
package aspl_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_TKO  = 6'h04,
    ST_TX   = 6'h08,
    ST_HOV  = 6'h10,
    ST_STOP = 6'h20
  } aspl_state_t;

  typedef struct packed {
    aspl_state_t st;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        low_seen;
    logic [11:0] per_cnt;
    logic [11:0] hi_cnt;
    logic [11:0] prev_per;
    logic [4:0]  bcnt;
    logic [23:0] sh;
    logic [11:0] tcnt;
    logic [4:0]  tbit;
    logic [15:0] txsh;
    logic [18:0] por;
    logic        cmd_mode;
    logic        analog_en;
    logic        line;
    logic        oe;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic        region;
    logic [15:0] wdata;
  } aspl_regs_t;

endpackage

/* design/aspl_link.sv */
// slave end of the single pin programming link of the angle sensor
`timescale 1ns/1ns
`include "aspl_consts.svh"
// ***************************************************************
// How it works
// - one pin carries analog output or the bidirectional link.
// - after reset and turn-on time the analog output runs from stored data.
// - the device only answers; the master steers every exchange.
// - data words follow the command; master writes them, device reads out.
// - reads carry one handover bit before and one after the data.
// - no rising edge for the idle timeout sends the link back to idle.
// - command mode opens memory and the control registers to the master.
// - command mode stays until power-on reset; nothing else ends it.
// - each bit is pulse width coded; long high is 1, short is 0.
// - most significant part goes first for commands and data.
// - command bits 7..5 are region; 000 memory, 001..011 reserved.
// - region 100 is register space; 101..111 reserved.
// - command bits 4..1 are the address, bit 0 the direction bit.
// - the idle timeout resets the link no later than 220 us.
// - the bit period lies between 10 and 100 us.
// - the entry slot lasts from power-on until at most 30 ms.
// ***************************************************************
module aspl_link #(
  parameter logic [18:0] TON_CYC   = 19'(`ASPL_TON_CYC),
  parameter logic [18:0] ENT_CYC   = 19'(`ASPL_ENT_CYC),
  // entry command and signature, values arbitrary
  parameter logic [7:0]  ENTRY_CMD = `ASPL_ENTRY_CMD,
  parameter logic [15:0] ENTRY_SIG = `ASPL_ENTRY_SIG
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // link pin
  input  wire logic        i_line,
  output logic             o_line,
  output logic             o_line_oe,
  // analog path and mode
  output logic             o_analog_en,
  output logic             o_cmd_mode,
  // memory and register access
  output logic             o_wr_strobe,
  output logic             o_rd_req,
  output logic             o_region_reg,
  output logic [3:0]       o_addr,
  output logic [15:0]      o_wr_data,
  input  wire logic [15:0] i_rd_data
);

  localparam logic [11:0] TO_CYC = 12'(`ASPL_TO_CYC);
  // synchroniser starts at the pulled-up idle level: no false start after reset
  localparam aspl_pkg::aspl_regs_t RST = '{st: aspl_pkg::ST_IDLE, s1: 1'b1, s2: 1'b1, s3: 1'b1,
                                           default: '0};

  aspl_pkg::aspl_regs_t q;
  aspl_pkg::aspl_regs_t next_q;

  logic        rise;
  logic        fall;
  logic        win;
  logic        bit_val;
  logic [11:0] ref_per;
  logic [11:0] qtr;
  logic [11:0] thr3;
  logic [23:0] nsh;

  // ***************************************************************
  // edge detection and bit timing helpers
  // ***************************************************************
  assign rise    = q.s2 & ~q.s3;
  assign fall    = ~q.s2 & q.s3;
  assign win     = (q.por < ENT_CYC);
  assign ref_per = (q.bcnt == 5'h00) ? q.per_cnt : q.prev_per;
  assign bit_val = ({q.hi_cnt[10:0], 1'b0} > ref_per);
  assign nsh     = {q.sh[22:0], bit_val};
  assign qtr     = {2'h0, q.prev_per[11:2]};
  assign thr3    = qtr + {1'b0, q.prev_per[11:1]};

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_q    = q;
    next_q.s1 = i_line;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.wr = 1'b0;
    next_q.rd = 1'b0;
    if (win) begin
      next_q.por = q.por + 19'h1;
    end
    // analog path only outside command mode
    next_q.analog_en = (q.por >= TON_CYC) & ~q.cmd_mode;
    if (rise) begin
      next_q.per_cnt = 12'h000;
    end else if (q.per_cnt != TO_CYC) begin
      next_q.per_cnt = q.per_cnt + 12'h001;
    end
    unique case (q.st)
      aspl_pkg::ST_IDLE: begin
        // slave drives only inside a read
        next_q.oe = 1'b0;
        if (!q.s2) begin
          next_q.low_seen = 1'b1;
        end
        if (rise && q.low_seen) begin
          next_q.st       = aspl_pkg::ST_RX;
          next_q.bcnt     = 5'h00;
          next_q.hi_cnt   = 12'h000;
          next_q.low_seen = 1'b0;
        end
      end
      aspl_pkg::ST_RX: begin
        if (q.s2) begin
          next_q.hi_cnt = q.hi_cnt + 12'h001;
        end
        if (rise) begin
          // each rise closes the bit before it
          next_q.sh       = nsh;
          next_q.bcnt     = q.bcnt + 5'h01;
          next_q.prev_per = q.per_cnt;
          next_q.hi_cnt   = 12'h000;
          if (q.bcnt == `ASPL_CMD_BITS) begin
            if (nsh[6:5] != 2'h0) begin
              next_q.st = aspl_pkg::ST_IDLE;
            end else if (nsh[0]) begin
              if (q.cmd_mode) begin
                next_q.rd     = 1'b1;
                next_q.addr   = nsh[4:1];
                next_q.region = nsh[7];
                next_q.st     = aspl_pkg::ST_TKO;
              end else begin
                next_q.st = aspl_pkg::ST_IDLE;
              end
            end else if (!q.cmd_mode && !(nsh[7:0] == ENTRY_CMD && win)) begin
              next_q.st = aspl_pkg::ST_IDLE;
            end
          end
          if (q.bcnt == `ASPL_FRAME_BITS) begin
            // this rise is the stop condition
            next_q.st = aspl_pkg::ST_IDLE;
            if (q.cmd_mode) begin
              next_q.wr     = 1'b1;
              next_q.addr   = nsh[20:17];
              next_q.region = nsh[23];
              next_q.wdata  = nsh[15:0];
            end else if (nsh[23:16] == ENTRY_CMD && nsh[15:0] == ENTRY_SIG && win) begin
              next_q.cmd_mode = 1'b1;
            end
          end
        end
      end
      aspl_pkg::ST_TKO: begin
        next_q.line = 1'b0;
        // takeover low begins at the end of the master handover pulse
        if (fall) begin
          next_q.oe = 1'b1;
        end
        if (q.oe && q.per_cnt >= q.prev_per) begin
          next_q.st   = aspl_pkg::ST_TX;
          next_q.txsh = i_rd_data;
          next_q.tbit = 5'h00;
          next_q.tcnt = 12'h000;
        end
      end
      aspl_pkg::ST_TX: begin
        // high a quarter for 0, three quarters for 1
        next_q.line = (q.tcnt < (q.txsh[15] ? thr3 : qtr));
        next_q.tcnt = q.tcnt + 12'h001;
        if (q.tcnt == q.prev_per - 12'h001) begin
          next_q.tcnt = 12'h000;
          next_q.txsh = {q.txsh[14:0], 1'b0};
          next_q.tbit = q.tbit + 5'h01;
          if (q.tbit == `ASPL_TX_LAST) begin
            next_q.st = aspl_pkg::ST_HOV;
          end
        end
      end
      aspl_pkg::ST_HOV: begin
        // handover zero, released at three quarters
        next_q.line = (q.tcnt < qtr);
        next_q.tcnt = q.tcnt + 12'h001;
        if (q.tcnt == thr3) begin
          next_q.oe   = 1'b0;
          next_q.line = 1'b0;
          next_q.st   = aspl_pkg::ST_STOP;
        end
      end
      aspl_pkg::ST_STOP: begin
        if (rise) begin
          next_q.st       = aspl_pkg::ST_IDLE;
          next_q.low_seen = 1'b0;
        end
      end
    endcase
    // silence of the line resynchronises the slave
    if (q.per_cnt == TO_CYC && q.st != aspl_pkg::ST_IDLE) begin
      next_q.st   = aspl_pkg::ST_IDLE;
      next_q.oe   = 1'b0;
      next_q.line = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign o_line       = q.line;
  assign o_line_oe    = q.oe;
  assign o_analog_en  = q.analog_en;
  assign o_cmd_mode   = q.cmd_mode;
  assign o_wr_strobe  = q.wr;
  assign o_rd_req     = q.rd;
  assign o_region_reg = q.region;
  assign o_addr       = q.addr;
  assign o_wr_data    = q.wdata;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_read_taken;
    o_rd_req ##1 (q.st == aspl_pkg::ST_TKO);
  endsequence

  sequence s_no_drive_until_tx;
    !o_line_oe ##1 (q.st != aspl_pkg::ST_TX);
  endsequence

  chk_idle_timeout: assert property (
    (q.per_cnt == TO_CYC && q.st != aspl_pkg::ST_IDLE) |=> (q.st == aspl_pkg::ST_IDLE && !o_line_oe))
    else $error("link not idle after timeout");

  chk_cmd_sticky: assert property (
    o_cmd_mode |=> o_cmd_mode)
    else $error("command mode left without reset");

  chk_entry_window: assert property (
    $rose(o_cmd_mode) |-> $past(win, 2))
    else $error("command mode entered outside slot");

  chk_analog_mode: assert property (
    o_analog_en |-> (!o_cmd_mode || $past(q.st) == aspl_pkg::ST_RX))
    else $error("analog output on in command mode");

  chk_reserved_drop: assert property (
    (q.st == aspl_pkg::ST_RX && rise && q.bcnt == `ASPL_CMD_BITS && nsh[6:5] != 2'h0)
      |=> (q.st == aspl_pkg::ST_IDLE && !o_rd_req) ##1 s_no_drive_until_tx)
    else $error("reserved region not dropped");

  chk_read_pulse: assert property (
    $rose(o_rd_req) |-> s_read_taken ##0 !o_rd_req)
    else $error("read request not one cycle into takeover");

  chk_tx_width: assert property (
    (q.st == aspl_pkg::ST_TX && q.tcnt == {1'b0, q.prev_per[11:1]})
      |=> (o_line == $past(q.txsh[15])))
    else $error("transmitted pulse width wrong");

  chk_wr_mode: assert property (
    o_wr_strobe |-> (o_cmd_mode && $past(rise)) ##1 !o_wr_strobe)
    else $error("write strobe outside command mode");

  chk_hov_release: assert property (
    (q.st == aspl_pkg::ST_HOV && q.tcnt == thr3) |=> (!o_line_oe && !o_line)[*2])
    else $error("handover bit not released");

  chk_drive_only_read: assert property (
    o_line_oe |-> (q.st inside {aspl_pkg::ST_TKO, aspl_pkg::ST_TX, aspl_pkg::ST_HOV}))
    else $error("slave drives the pin outside a read");

  chk_takeover_low: assert property (
    (q.st == aspl_pkg::ST_TKO && o_line_oe) |-> !o_line)
    else $error("takeover level not low");

  chk_tx_load: assert property (
    (q.st == aspl_pkg::ST_TX && $past(q.st) == aspl_pkg::ST_TKO)
      |-> (q.txsh == $past(i_rd_data)))
    else $error("read word not loaded");

  chk_word_length: assert property (
    (q.st == aspl_pkg::ST_HOV && $past(q.st) == aspl_pkg::ST_TX) |-> (q.tbit == 5'h10))
    else $error("handover not after sixteen bits");

  chk_read_in_mode: assert property (
    o_rd_req |-> (o_cmd_mode && q.st == aspl_pkg::ST_TKO))
    else $error("read request outside command mode");

endmodule // aspl_link

/* tb/aspl_master_model.sv */
// programming master model for the single pin link
`timescale 1ns/1ns
module aspl_master_model #(
  parameter int T = 200
) (
  input  wire logic i_clk_sys,
  input  wire logic i_line,
  output logic      o_drv,
  output logic      o_oe
);
  initial begin
    o_drv = 1'h1;
    o_oe  = 1'h1;
  end
  // one bit: rise, then long or short high
  task automatic send_bit(input logic b);
    o_drv <= 1'h1;
    repeat (b ? 3*T/4 : T/4) @(posedge i_clk_sys);
    o_drv <= 1'h0;
    repeat (b ? T/4 : 3*T/4) @(posedge i_clk_sys);
  endtask
  // low time, start rise, n bits msb first, optional stop rise
  task automatic send(input logic [23:0] v, input int n, input logic stop);
    o_oe  <= 1'h1;
    o_drv <= 1'h0;
    repeat (60) @(posedge i_clk_sys);
    for (int i = n-1; i >= 0; i--) send_bit(v[i]);
    if (stop) begin
      o_drv <= 1'h1;
      repeat (T) @(posedge i_clk_sys);
    end
  endtask
  // read: command, handover zero, 16 slave bits, slave handover, stop
  task automatic read(input logic [7:0] c, output logic [15:0] d, output logic ok);
    int h;
    int w;
    send({16'h0000, c}, 8, 1'h0);
    o_drv <= 1'h1;
    repeat (T/4) @(posedge i_clk_sys);
    o_drv <= 1'h0;
    repeat (T/2) @(posedge i_clk_sys);
    o_oe  <= 1'h0;
    ok = 1'h1;
    for (int k = 0; k < 17; k++) begin
      w = 0;
      while (i_line !== 1'h1 && w < 2*T) begin @(posedge i_clk_sys); w++; end
      h = 0;
      while (i_line === 1'h1 && h < T) begin @(posedge i_clk_sys); h++; end
      if (w >= 2*T || h >= T) ok = 1'h0;
      if (k < 16) d = {d[14:0], 2*h > T};
    end
    o_oe  <= 1'h1;
    o_drv <= 1'h0;
    repeat (T) @(posedge i_clk_sys);
    o_drv <= 1'h1;
    repeat (T) @(posedge i_clk_sys);
  endtask
endmodule // aspl_master_model

/* tb/angle_sensor_programming_link_tb.sv */
// self-checking bench of the programming link slave
`timescale 1ns/1ns
`include "aspl_consts.svh"
module angle_sensor_programming_link_tb;
  logic        i_clk_sys = 1'h0;
  logic        i_rst     = 1'h1;
  logic        m_drv, m_oe, o_line, o_line_oe, o_analog_en, o_cmd_mode;
  logic        o_wr_strobe, o_rd_req, o_region_reg, oe_seen, ok;
  logic [3:0]  o_addr;
  logic [15:0] o_wr_data, rd_data, d;
  logic        line;
  int          n_wr, n_rd, bad_count, samples_checked;
  always #50 i_clk_sys = ~i_clk_sys;
  // pull-up when nobody drives
  assign line = m_oe ? m_drv : (o_line_oe ? o_line : 1'h1);
  initial rd_data = 16'h0000;
  aspl_master_model #(.T(200)) u_mst (.i_clk_sys(i_clk_sys), .i_line(line),
    .o_drv(m_drv), .o_oe(m_oe));
  aspl_link #(.TON_CYC(19'h00032), .ENT_CYC(19'h02EE0)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_line(line), .o_line(o_line),
    .o_line_oe(o_line_oe), .o_analog_en(o_analog_en), .o_cmd_mode(o_cmd_mode),
    .o_wr_strobe(o_wr_strobe), .o_rd_req(o_rd_req), .o_region_reg(o_region_reg),
    .o_addr(o_addr), .o_wr_data(o_wr_data), .i_rd_data(rd_data));
  always @(posedge i_clk_sys) begin
    if (o_wr_strobe === 1'h1) n_wr++;
    if (o_rd_req === 1'h1) n_rd++;
    if (o_line_oe === 1'h1) oe_seen = 1'h1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    @(posedge i_clk_sys);
    #1 check(16'({o_line_oe, o_analog_en, o_cmd_mode, o_wr_strobe, o_rd_req}), 16'h0000);
    repeat (40) @(posedge i_clk_sys);
    #1 check(16'(o_analog_en), 16'h0000);
    repeat (20) @(posedge i_clk_sys);
    #1 check(16'({o_analog_en, o_line_oe}), 16'h0002);
    $display("test reset done");
  endtask
  task automatic t_entry;
    oe_seen = 1'h0;
    u_mst.send({`ASPL_ENTRY_CMD, 16'h1234}, 24, 1'h1);
    #1 check(16'(o_cmd_mode), 16'h0000);
    u_mst.send({`ASPL_ENTRY_CMD, `ASPL_ENTRY_SIG}, 24, 1'h1);
    #1 check(16'({o_cmd_mode, o_analog_en, oe_seen}), 16'h0004);
    check(16'(n_wr), 16'h0000);
    $display("test entry done");
  endtask
  task automatic t_write(input logic [7:0] c, input logic [15:0] v);
    int n0;
    n0 = n_wr;
    u_mst.send({c, v}, 24, 1'h1);
    check(16'(n_wr - n0), 16'h0001);
    check(o_wr_data, v);
    check(16'({o_region_reg, o_addr}), {11'h000, c[7], c[4:1]});
    $display("test write %h done", c);
  endtask
  task automatic t_read;
    int n0;
    n0 = n_rd;
    rd_data <= 16'hA5C3;
    u_mst.read(8'h85, d, ok);
    check(16'(ok), 16'h0001);
    check(d, 16'hA5C3);
    check(16'(n_rd - n0), 16'h0001);
    check(16'({o_region_reg, o_addr}), 16'h0012);
    $display("test read done");
  endtask
  task automatic t_reserved;
    int n0;
    int n1;
    for (int r = 1; r < 8; r++) begin
      if (r == 4) continue;
      n0 = n_wr;
      n1 = n_rd;
      oe_seen = 1'h0;
      u_mst.send({16'h0000, 3'(r), 4'h1, 1'h1}, 8, 1'h1);
      repeat (2400) @(posedge i_clk_sys);
      check({oe_seen, 7'(n_wr - n0), 8'(n_rd - n1)}, 16'h0000);
    end
    $display("test reserved done");
  endtask
  task automatic t_timeout;
    u_mst.send(24'h0A0000, 12, 1'h0);
    repeat (2000) @(posedge i_clk_sys);
    t_write(8'h1C, 16'h8001);
    check(16'(o_cmd_mode), 16'h0001);
    $display("test timeout done");
  endtask
  initial begin
    t_reset();
    t_entry();
    // control register write enables the pump, then it settles
    t_write(8'h86, 16'h0001);
    repeat (`ASPL_PUMP_CYC) @(posedge i_clk_sys);
    t_write(8'h0A, 16'hC35A);
    t_write(8'h1E, 16'h003C);
    t_read();
    t_reserved();
    t_timeout();
    test_done();
  end
endmodule // angle_sensor_programming_link_tb
